//--- core/plc_line_ctrl.sv
// per-line controller: axi4-lite register file, ownership, drive and pin sampling
`timescale 1ns/1ps
module plc_line_ctrl #(
  parameter logic [31:0] OWNER_RESET = plc_pkg::PLC_RST_OWNER,
  parameter logic [31:0] LINES_DEFINED = plc_pkg::PLC_DEF_LINES,
  parameter logic [31:0] GP_ONLY = plc_pkg::PLC_DEF_GP_ONLY
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // gate from the power clock manager
  input wire logic ctrl_clk_en,
  // register bus
  input wire plc_pkg::plc_axi_req_type s_axi_req,
  output plc_pkg::plc_axi_rsp_type s_axi_rsp,
  // peripheral functions
  input wire plc_pkg::plc_periph_type periph_a,
  input wire plc_pkg::plc_periph_type periph_b,
  output logic [31:0] periph_in,
  // pins
  input wire logic [31:0] pin_in,
  output plc_pkg::plc_pad_type pad,
  // per-line change pulses for an outside interrupt stage
  output logic [31:0] line_change
);
  import plc_pkg::*;

  // lines that may ever change hands; the rest stay with the controller
  localparam logic [31:0] MUXABLE = LINES_DEFINED & ~GP_ONLY;

  // reset image of the whole state
  localparam plc_state_type RESET_STATE = '{
    aw_full: 1'b0,
    aw_addr: 8'h00,
    w_full: 1'b0,
    w_data: PLC_RST_ZERO,
    w_strb: 4'h0,
    bvalid: 1'b0,
    bresp: PLC_RESP_OKAY,
    rvalid: 1'b0,
    rdata: PLC_RST_ZERO,
    rresp: PLC_RESP_OKAY,
    owner: OWNER_RESET | GP_ONLY,
    sel: PLC_RST_ZERO,
    oe: PLC_RST_ZERO,
    ods: PLC_RST_ZERO,
    mask: PLC_RST_ZERO,
    md: PLC_RST_ZERO,
    pu_off: PLC_RST_ZERO,
    pin_s1: PLC_RST_ZERO,
    pin_s2: PLC_RST_ZERO,
    pin_level: PLC_RST_ZERO,
    pin_prev: PLC_RST_ZERO,
    change: PLC_RST_ZERO,
    pad_out: PLC_RST_ZERO,
    pad_oe: PLC_RST_ZERO
  };

  // registered state and its next value
  plc_state_type state_reg;
  plc_state_type state_next;

  // write strobe widened to a bit mask
  function automatic logic [31:0] strb_bits(input logic [3:0] strb);
    logic [31:0] bits;
    bits = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      bits[i*8 +: 8] = {8{strb[i]}};
    end
    return bits;
  endfunction

  // true for every offset that answers a write
  function automatic logic wr_mapped(input logic [7:0] addr);
    case (addr)
      PLC_OFF_OWNER_EN, PLC_OFF_OWNER_DIS, PLC_OFF_OE_SET, PLC_OFF_OE_CLR,
      PLC_OFF_OD_SET, PLC_OFF_OD_CLR, PLC_OFF_OD_STAT, PLC_OFF_MD_SET,
      PLC_OFF_MD_CLR, PLC_OFF_PU_ON, PLC_OFF_PU_OFF, PLC_OFF_SEL_A,
      PLC_OFF_SEL_B, PLC_OFF_WM_SET, PLC_OFF_WM_CLR: begin
        return 1'b1;
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction

  // true for every offset that answers a read
  function automatic logic rd_mapped(input logic [7:0] addr);
    case (addr)
      PLC_OFF_OWNER_EN, PLC_OFF_OWNER_DIS, PLC_OFF_OWNER_STAT, PLC_OFF_OE_SET,
      PLC_OFF_OE_CLR, PLC_OFF_OE_STAT, PLC_OFF_OD_SET, PLC_OFF_OD_CLR,
      PLC_OFF_OD_STAT, PLC_OFF_PIN_STAT, PLC_OFF_MD_SET, PLC_OFF_MD_CLR,
      PLC_OFF_MD_STAT, PLC_OFF_PU_ON, PLC_OFF_PU_OFF, PLC_OFF_PU_STAT,
      PLC_OFF_SEL_A, PLC_OFF_SEL_B, PLC_OFF_SEL_STAT, PLC_OFF_WM_SET,
      PLC_OFF_WM_CLR, PLC_OFF_WM_STAT: begin
        return 1'b1;
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction

  // read data of one offset; write-only offsets and undefined lines read zero
  function automatic logic [31:0] rd_value(input logic [7:0] addr,
                                           input plc_state_type s);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (addr)
      PLC_OFF_OWNER_STAT: begin
        v = s.owner | GP_ONLY;
      end
      PLC_OFF_OE_STAT: begin
        v = s.oe;
      end
      PLC_OFF_OD_STAT: begin
        v = s.ods;
      end
      PLC_OFF_PIN_STAT: begin
        v = s.pin_level;
      end
      PLC_OFF_MD_STAT: begin
        v = s.md;
      end
      PLC_OFF_PU_STAT: begin
        v = s.pu_off;
      end
      PLC_OFF_SEL_STAT: begin
        v = s.sel;
      end
      PLC_OFF_WM_STAT: begin
        v = s.mask;
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v & LINES_DEFINED;
  endfunction

  // next state: bus slave, register updates, sampling and drive
  always_comb begin
    logic [31:0] wbits;
    logic [31:0] wset;
    logic [31:0] wauth;
    logic wr_go;
    logic [31:0] p_out;
    logic [31:0] p_oe;
    logic [31:0] own_oe;
    logic [31:0] drv_out;
    logic [31:0] drv_oe;
    state_next = state_reg;
    wbits = 32'h0000_0000;
    wset = 32'h0000_0000;
    wauth = 32'h0000_0000;
    wr_go = 1'b0;
    p_out = 32'h0000_0000;
    p_oe = 32'h0000_0000;
    own_oe = 32'h0000_0000;
    drv_out = 32'h0000_0000;
    drv_oe = 32'h0000_0000;

    // response handshakes retire the answer
    if (state_reg.bvalid && s_axi_req.bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.rvalid && s_axi_req.rready) begin
      state_next.rvalid = 1'b0;
    end

    // address and data are caught independently, in either order
    if (!state_reg.aw_full && s_axi_req.awvalid) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = {s_axi_req.awaddr[7:2], 2'b00};
    end
    if (!state_reg.w_full && s_axi_req.wvalid) begin
      state_next.w_full = 1'b1;
      state_next.w_data = s_axi_req.wdata;
      state_next.w_strb = s_axi_req.wstrb;
    end

    // a write executes once both halves are held and no response is pending;
    // config writes never look at ctrl_clk_en so they land with the clock gated
    wr_go = state_reg.aw_full && state_reg.w_full && !state_reg.bvalid;
    if (wr_go) begin
      wbits = strb_bits(state_reg.w_strb);
      // zero bits and undefined lines change nothing
      wset = state_reg.w_data & wbits & LINES_DEFINED;
      state_next.aw_full = 1'b0;
      state_next.w_full = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = wr_mapped(state_reg.aw_addr) ? PLC_RESP_OKAY : PLC_RESP_SLVERR;
      case (state_reg.aw_addr)
        PLC_OFF_OWNER_EN: begin
          state_next.owner = state_reg.owner | wset;
        end
        PLC_OFF_OWNER_DIS: begin
          // general-purpose lines cannot be given away
          state_next.owner = state_reg.owner & ~(wset & MUXABLE);
        end
        PLC_OFF_OE_SET: begin
          state_next.oe = state_reg.oe | wset;
        end
        PLC_OFF_OE_CLR: begin
          state_next.oe = state_reg.oe & ~wset;
        end
        PLC_OFF_OD_SET: begin
          state_next.ods = state_reg.ods | wset;
        end
        PLC_OFF_OD_CLR: begin
          state_next.ods = state_reg.ods & ~wset;
        end
        PLC_OFF_OD_STAT: begin
          // direct write: ones and zeros both land, but only where authorised
          wauth = state_reg.mask & wbits & LINES_DEFINED;
          state_next.ods = (state_reg.ods & ~wauth) | (state_reg.w_data & wauth);
        end
        PLC_OFF_MD_SET: begin
          state_next.md = state_reg.md | wset;
        end
        PLC_OFF_MD_CLR: begin
          state_next.md = state_reg.md & ~wset;
        end
        PLC_OFF_PU_ON: begin
          state_next.pu_off = state_reg.pu_off & ~wset;
        end
        PLC_OFF_PU_OFF: begin
          state_next.pu_off = state_reg.pu_off | wset;
        end
        PLC_OFF_SEL_A: begin
          // select moves whatever the owner bit says
          state_next.sel = state_reg.sel & ~wset;
        end
        PLC_OFF_SEL_B: begin
          state_next.sel = state_reg.sel | wset;
        end
        PLC_OFF_WM_SET: begin
          state_next.mask = state_reg.mask | wset;
        end
        PLC_OFF_WM_CLR: begin
          state_next.mask = state_reg.mask & ~wset;
        end
        default: begin
          // status offsets other than PLC_OFF_OD_STAT, and unmapped offsets, keep every bit
          state_next.owner = state_reg.owner;
        end
      endcase
    end

    // read: one outstanding, answered the cycle after it is taken
    if (!state_reg.rvalid && s_axi_req.arvalid) begin
      state_next.rvalid = 1'b1;
      if (rd_mapped({s_axi_req.araddr[7:2], 2'b00})) begin
        state_next.rdata = rd_value({s_axi_req.araddr[7:2], 2'b00}, state_reg);
        state_next.rresp = PLC_RESP_OKAY;
      end else begin
        state_next.rdata = 32'h0000_0000;
        state_next.rresp = PLC_RESP_SLVERR;
      end
    end

    // pin synchroniser; the first stage feeds only the second
    state_next.pin_s1 = pin_in;
    state_next.pin_s2 = state_reg.pin_s1;

    // sampling and change detect only run while the controller clock is on;
    // with it off the last sampled level is frozen for software to read
    state_next.change = 32'h0000_0000;
    if (ctrl_clk_en) begin
      state_next.pin_level = state_reg.pin_s2;
      state_next.pin_prev = state_reg.pin_s2;
      state_next.change = (state_reg.pin_s2 ^ state_reg.pin_prev) & LINES_DEFINED;
    end

    // selected peripheral request; select only steers the drive path
    p_out = (state_reg.sel & periph_b.out) | (~state_reg.sel & periph_a.out);
    p_oe = (state_reg.sel & periph_b.oe) | (~state_reg.sel & periph_a.oe);

    // controller-owned lines use oe/ods, the rest follow the peripheral
    drv_out = (state_reg.owner & state_reg.ods) | (~state_reg.owner & p_out);
    own_oe = (state_reg.owner & state_reg.oe) | (~state_reg.owner & p_oe);

    // open drain: drive low only, release for a one
    drv_oe = (state_reg.md & own_oe & ~drv_out) | (~state_reg.md & own_oe);
    state_next.pad_out = ~state_reg.md & drv_out & LINES_DEFINED;
    state_next.pad_oe = drv_oe & LINES_DEFINED;

    // keep general-purpose lines owned even if the reset parameter disagrees
    state_next.owner = state_next.owner | GP_ONLY;
  end

  // single state register; synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // bus answers; readies are plain flag inversions
  always_comb begin
    s_axi_rsp.awready = !state_reg.aw_full;
    s_axi_rsp.wready = !state_reg.w_full;
    s_axi_rsp.bvalid = state_reg.bvalid;
    s_axi_rsp.bresp = state_reg.bresp;
    s_axi_rsp.arready = !state_reg.rvalid;
    s_axi_rsp.rvalid = state_reg.rvalid;
    s_axi_rsp.rdata = state_reg.rdata;
    s_axi_rsp.rresp = state_reg.rresp;
  end

  // pad and peripheral side; peripheral inputs see the pin on every line,
  // ungated by the controller clock enable
  always_comb begin
    pad.out = state_reg.pad_out;
    pad.oe = state_reg.pad_oe;
    pad.pullup_en = ~state_reg.pu_off & LINES_DEFINED;
    periph_in = state_reg.pin_s2;
    line_change = state_reg.change;
  end

endmodule

//--- core/plc_pkg.sv
// constants, register map and carrier types for the parallel line controller
package plc_pkg;

  localparam int PLC_LINES = 32;
  localparam int PLC_ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] PLC_OFF_OWNER_EN = 8'h00;
  localparam logic [7:0] PLC_OFF_OWNER_DIS = 8'h04;
  localparam logic [7:0] PLC_OFF_OWNER_STAT = 8'h08;
  localparam logic [7:0] PLC_OFF_OE_SET = 8'h10;
  localparam logic [7:0] PLC_OFF_OE_CLR = 8'h14;
  localparam logic [7:0] PLC_OFF_OE_STAT = 8'h18;
  localparam logic [7:0] PLC_OFF_OD_SET = 8'h30;
  localparam logic [7:0] PLC_OFF_OD_CLR = 8'h34;
  localparam logic [7:0] PLC_OFF_OD_STAT = 8'h38;
  localparam logic [7:0] PLC_OFF_PIN_STAT = 8'h3C;
  localparam logic [7:0] PLC_OFF_MD_SET = 8'h50;
  localparam logic [7:0] PLC_OFF_MD_CLR = 8'h54;
  localparam logic [7:0] PLC_OFF_MD_STAT = 8'h58;
  localparam logic [7:0] PLC_OFF_PU_ON = 8'h60;
  localparam logic [7:0] PLC_OFF_PU_OFF = 8'h64;
  localparam logic [7:0] PLC_OFF_PU_STAT = 8'h68;
  localparam logic [7:0] PLC_OFF_SEL_A = 8'h70;
  localparam logic [7:0] PLC_OFF_SEL_B = 8'h74;
  localparam logic [7:0] PLC_OFF_SEL_STAT = 8'h78;
  localparam logic [7:0] PLC_OFF_WM_SET = 8'h80;
  localparam logic [7:0] PLC_OFF_WM_CLR = 8'h84;
  localparam logic [7:0] PLC_OFF_WM_STAT = 8'h88;

  // reset values and product defaults
  localparam logic [31:0] PLC_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] PLC_RST_OWNER = 32'hFFFF_FFFF;
  localparam logic [31:0] PLC_DEF_LINES = 32'hFFFF_FFFF;
  localparam logic [31:0] PLC_DEF_GP_ONLY = 32'h0000_0000;

  // bus responses
  localparam logic [1:0] PLC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PLC_RESP_SLVERR = 2'h2;

  // axi4-lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } plc_axi_req_type;

  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } plc_axi_rsp_type;

  // drive request of one peripheral function, one bit per line
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } plc_periph_type;

  // pad control towards the pins
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
    logic [31:0] pullup_en;
  } plc_pad_type;

  // whole state of the controller
  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] owner;
    logic [31:0] sel;
    logic [31:0] oe;
    logic [31:0] ods;
    logic [31:0] mask;
    logic [31:0] md;
    logic [31:0] pu_off;
    logic [31:0] pin_s1;
    logic [31:0] pin_s2;
    logic [31:0] pin_level;
    logic [31:0] pin_prev;
    logic [31:0] change;
    logic [31:0] pad_out;
    logic [31:0] pad_oe;
  } plc_state_type;

endpackage

//--- verification/plc_line_assertions.sv
// port assertions for the parallel line controller
`timescale 1ns/1ps
module plc_line_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ctrl_clk_en,
  // register bus
  input wire plc_pkg::plc_axi_req_type s_axi_req,
  input wire plc_pkg::plc_axi_rsp_type s_axi_rsp,
  // far side
  input wire plc_pkg::plc_periph_type periph_a,
  input wire plc_pkg::plc_periph_type periph_b,
  input wire logic [31:0] periph_in,
  input wire logic [31:0] pin_in,
  input wire plc_pkg::plc_pad_type pad,
  input wire logic [31:0] line_change
);
  import plc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence wr_go;
    s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid && s_axi_rsp.wready;
  endsequence
  sequence wr_at(logic [7:0] a);
    wr_go ##0 (s_axi_req.awaddr == a);
  endsequence
  sequence rd_at(logic [7:0] a);
    s_axi_req.arvalid && s_axi_rsp.arready && s_axi_req.araddr == a;
  endsequence
  // guard the first edges after reset, where the sync flops are still cleared
  sync_path_a: assert property ($past(aresetn, 2) && $past(aresetn) |->
    periph_in == $past(pin_in, 2)) else $error("periph_in lags the pin wrongly");
  gated_change_a: assert property (|line_change |-> $past(ctrl_clk_en))
    else $error("line change seen with the clock gated");
  // with the gate on for two edges a pulse marks exactly the lines whose synced level moved
  change_track_a: assert property ($past(aresetn, 4) && $past(aresetn, 3) &&
    $past(aresetn, 2) && $past(aresetn) && $past(ctrl_clk_en) && $past(ctrl_clk_en, 2)
    |-> line_change == ($past(pin_in, 3) ^ $past(pin_in, 4)))
    else $error("line change does not follow the sampled pins");
  wr_answer_a: assert property (wr_go |-> ##2 s_axi_rsp.bvalid)
    else $error("write answer late");
  unmapped_wr_a: assert property (wr_at(8'hFC) |-> ##2 s_axi_rsp.bresp == PLC_RESP_SLVERR)
    else $error("unmapped write not refused");
  ro_write_a: assert property (wr_at(PLC_OFF_OWNER_STAT) |-> ##2
    s_axi_rsp.bresp == PLC_RESP_SLVERR) else $error("status write not refused");
  unmapped_rd_a: assert property (rd_at(8'hFC) |=> s_axi_rsp.rvalid
    && s_axi_rsp.rresp == PLC_RESP_SLVERR && s_axi_rsp.rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  pullup_read_a: assert property (rd_at(PLC_OFF_PU_STAT) |=>
    s_axi_rsp.rdata == ~pad.pullup_en) else $error("pull-up pads disagree with status");
  drain_low_a: assert property (rd_at(PLC_OFF_MD_STAT) |=>
    (s_axi_rsp.rdata & pad.out) == 32'h0000_0000) else $error("open drain line driven high");
  reset_pads_a: assert property ($rose(aresetn) |-> pad.pullup_en == 32'hFFFF_FFFF
    && !s_axi_rsp.bvalid && !s_axi_rsp.rvalid) else $error("reset state wrong");
endmodule
bind plc_line_ctrl plc_line_chk chk (.aclk, .aresetn, .ctrl_clk_en, .s_axi_req, .s_axi_rsp,
  .periph_a, .periph_b, .periph_in, .pin_in, .pad, .line_change);

//--- verification/plc_pin_model.sv
// pin model: pad drivers, an outside driver, pull-ups and floating lines
`timescale 1ns/1ps
module plc_pin_model (
  // clock
  input wire logic aclk,
  // pad control from the controller
  input wire plc_pkg::plc_pad_type pad,
  // outside driver on the lines
  input wire logic [31:0] ext_oe,
  input wire logic [31:0] ext_val,
  // resolved line level
  output logic [31:0] pin_in
);
  import plc_pkg::*;
  logic [31:0] flt_reg = 32'h5555_5555; // undriven lines wander so no stale level survives
  // floating pattern changes every cycle
  always @(posedge aclk) begin
    flt_reg <= ~flt_reg;
  end
  // pad wins, then the outside driver; a released open-drain line rests on the pull-up
  assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext_oe & ext_val)
    | (~pad.oe & ~ext_oe & (pad.pullup_en | flt_reg));
endmodule

//--- verification/tb_top.sv
// self-checking bench for the parallel line controller
`timescale 1ns/1ps
module tb_top;
  import plc_pkg::*;
  localparam logic [31:0] OWN_RST = 32'hFFFF_0FFF; // lines 15:12 start on a peripheral
  localparam logic [31:0] GP = 32'h0000_000F; // lines 3:0 have no peripheral
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ctrl_clk_en = 1'b0;
  plc_axi_req_type req = '0;
  plc_axi_rsp_type rsp;
  plc_periph_type pa = '0;
  plc_periph_type pb = '0;
  plc_pad_type pad;
  logic [31:0] periph_in, pin_in, line_change;
  logic [31:0] ext_oe = '0;
  logic [31:0] ext_val = '0;
  logic [31:0] own, sel, oe, ods, msk, md, puo, eoe, eout; // expected state
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] st [7] = '{PLC_OFF_OWNER_STAT, PLC_OFF_OE_STAT, PLC_OFF_OD_STAT,
    PLC_OFF_MD_STAT, PLC_OFF_PU_STAT, PLC_OFF_SEL_STAT, PLC_OFF_WM_STAT};
  logic [7:0] ops [15] = '{PLC_OFF_OWNER_EN, PLC_OFF_OWNER_DIS, PLC_OFF_OE_SET,
    PLC_OFF_OE_CLR, PLC_OFF_OD_SET, PLC_OFF_OD_CLR, PLC_OFF_OD_STAT, PLC_OFF_MD_SET,
    PLC_OFF_MD_CLR, PLC_OFF_PU_ON, PLC_OFF_PU_OFF, PLC_OFF_SEL_A, PLC_OFF_SEL_B,
    PLC_OFF_WM_SET, PLC_OFF_WM_CLR};
  // fixed corner writes ahead of the random ones
  logic [7:0] fa [4] = '{PLC_OFF_OWNER_DIS, PLC_OFF_WM_SET, PLC_OFF_OD_STAT, PLC_OFF_SEL_B};
  logic [31:0] fd [4] = '{32'hFFFF_FFFF, 32'h0000_00F0, 32'hFFFF_FFFF, 32'h0000_FF00};
  always #2.5 aclk = ~aclk;
  plc_line_ctrl #(.OWNER_RESET(OWN_RST), .GP_ONLY(GP)) uut (.aclk, .aresetn, .ctrl_clk_en,
    .s_axi_req(req), .s_axi_rsp(rsp), .periph_a(pa), .periph_b(pb), .periph_in, .pin_in,
    .pad, .line_change);
  plc_pin_model pins (.aclk, .pad, .ext_oe, .ext_val, .pin_in);
  // verdict and end of run
  task automatic complete_run();
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, well above the roughly 1300 cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write with both halves offered together; each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (!ga && rsp.awready === 1'b1) begin
        req.awvalid <= 1'b0;
        ga = 1'b1;
      end
      if (!gw && rsp.wready === 1'b1) begin
        req.wvalid <= 1'b0;
        gw = 1'b1;
      end
    end
    do @(posedge aclk); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk_word("bresp", {30'h0, er}, {30'h0, rsp.bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge aclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    chk_word("rresp", {30'h0, er}, {30'h0, rsp.rresp});
    chk_word("rdata", ed, rsp.rdata);
  endtask
  // expected effect of one write on the status words
  task automatic upd(input logic [7:0] a, input logic [31:0] d);
    case (a)
      PLC_OFF_OWNER_EN: own = own | d;
      PLC_OFF_OWNER_DIS: own = (own & ~d) | GP;
      PLC_OFF_OE_SET: oe = oe | d;
      PLC_OFF_OE_CLR: oe = oe & ~d;
      PLC_OFF_OD_SET: ods = ods | d;
      PLC_OFF_OD_CLR: ods = ods & ~d;
      PLC_OFF_OD_STAT: ods = (ods & ~msk) | (d & msk);
      PLC_OFF_MD_SET: md = md | d;
      PLC_OFF_MD_CLR: md = md & ~d;
      PLC_OFF_PU_ON: puo = puo & ~d;
      PLC_OFF_PU_OFF: puo = puo | d;
      PLC_OFF_SEL_A: sel = sel & ~d;
      PLC_OFF_SEL_B: sel = sel | d;
      PLC_OFF_WM_SET: msk = msk | d;
      PLC_OFF_WM_CLR: msk = msk & ~d;
      default: ;
    endcase
  endtask
  function automatic logic [31:0] exp_stat(input logic [7:0] a);
    case (a)
      PLC_OFF_OWNER_STAT: return own;
      PLC_OFF_OE_STAT: return oe;
      PLC_OFF_OD_STAT: return ods;
      PLC_OFF_MD_STAT: return md;
      PLC_OFF_PU_STAT: return puo;
      PLC_OFF_SEL_STAT: return sel;
      default: return msk;
    endcase
  endfunction
  task automatic chk_stat();
    for (int i = 0; i < 7; i++) rd(st[i], PLC_RESP_OKAY, exp_stat(st[i]));
  endtask
  // pads from owner, select and open drain; one idle edge lets the pad flops land
  task automatic chk_pad();
    for (int i = 0; i < 32; i++) begin
      eoe[i] = own[i] ? oe[i] : (sel[i] ? pb.oe[i] : pa.oe[i]);
      eout[i] = own[i] ? ods[i] : (sel[i] ? pb.out[i] : pa.out[i]);
      if (md[i]) begin
        eoe[i] = eoe[i] & ~eout[i];
        eout[i] = 1'b0;
      end
    end
    @(posedge aclk);
    chk_word("pad_oe", eoe, pad.oe);
    chk_word("pad_out", eout, pad.out);
    chk_word("pullup_en", ~puo, pad.pullup_en);
  endtask
  // main sequence
  initial begin
    logic [31:0] d, v, chg;
    logic [7:0] a;
    void'($urandom(62));
    own = OWN_RST;
    {sel, oe, ods, msk, md, puo} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk_stat();
    wr(8'hFC, $urandom, PLC_RESP_SLVERR);
    rd(8'hFC, PLC_RESP_SLVERR, 32'h0000_0000);
    wr(PLC_OFF_OWNER_STAT, 32'h0000_F000, PLC_RESP_SLVERR);
    rd(PLC_OFF_OWNER_EN, PLC_RESP_OKAY, 32'h0000_0000);
    for (int k = 0; k < 48; k++) begin
      a = k < 4 ? fa[k] : ops[$urandom_range(14)];
      d = k < 4 ? fd[k] : $urandom;
      ctrl_clk_en <= 1'($urandom_range(1));
      pa <= {$urandom, $urandom};
      pb <= {$urandom, $urandom};
      ext_oe <= $urandom;
      ext_val <= $urandom;
      wr(a, d, PLC_RESP_OKAY);
      upd(a, d);
      chk_pad();
      chk_stat();
    end
    // pin levels with the clock on, then frozen once it is gated
    v = $urandom;
    ext_oe <= '1;
    ext_val <= v;
    ctrl_clk_en <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(PLC_OFF_PIN_STAT, PLC_RESP_OKAY, (eoe & eout) | (~eoe & v));
    ctrl_clk_en <= 1'b0;
    ext_val <= ~v;
    // pins move while gated: no change pulse may leave the block
    chg = 32'h0000_0000;
    repeat (4) begin
      @(posedge aclk);
      chg = chg | line_change;
    end
    chk_word("line_change", 32'h0000_0000, chg);
    rd(PLC_OFF_PIN_STAT, PLC_RESP_OKAY, (eoe & eout) | (~eoe & v));
    chk_word("periph_in", (eoe & eout) | (~eoe & ~v), periph_in);
    // clock back on: every undriven line moved while gated, so each reports once
    ctrl_clk_en <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_word("line_change", ~eoe, line_change);
    complete_run();
  end
endmodule
